// ==== reg_access_pkg.sv ====
package reg_access_pkg;

  // Field access kinds understood by field_cell
  localparam int FA_RW  = 0;
  localparam int FA_RC  = 1;
  localparam int FA_WC  = 2;
  localparam int FA_W1C = 3;
  localparam int FA_W1S = 4;

  // Register offsets from the bank base address
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_ERRLAT = 12'h008;
  localparam logic [11:0] OFS_FAULT  = 12'h00C;
  localparam logic [11:0] OFS_INTST  = 12'h010;
  localparam logic [11:0] OFS_SETREQ = 12'h014;
  localparam logic [11:0] OFS_PEND   = 12'h018;
  localparam logic [11:0] OFS_CMD    = 12'h01C;

  // Register select indices
  localparam int SEL_CTRL   = 0;
  localparam int SEL_STATUS = 1;
  localparam int SEL_ERRLAT = 2;
  localparam int SEL_FAULT  = 3;
  localparam int SEL_INTST  = 4;
  localparam int SEL_SETREQ = 5;
  localparam int SEL_PEND   = 6;
  localparam int SEL_CMD    = 7;
  localparam int NUM_REGS   = 8;

  // Decode window: offsets with this bit or any bit above it set are outside the bank
  localparam int OFS_BITS = 12;

  // Reset values
  localparam logic [31:0] DEF_BASE  = 32'h4000_0000;
  localparam logic [31:0] CTRL_RST  = 32'h0000_00FF;
  localparam logic [31:0] ZERO_RST  = 32'h0000_0000;

endpackage

// ==== field_cell.sv ====
`timescale 1ns/1ps

module field_cell
  import reg_access_pkg::*;
#(
  parameter int               WIDTH   = 8,
  parameter int               MODE    = FA_RW,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input  wire logic             core_clk_in, // System clock
  input  wire logic             rstn_in,     // Async reset, active low
  input  wire logic             wr_in,       // Software write to this register
  input  wire logic             rd_in,       // Software read of this register
  input  wire logic [WIDTH-1:0] wdata_in,    // Software write data
  input  wire logic [WIDTH-1:0] hw_set_in,   // Hardware set per bit
  input  wire logic [WIDTH-1:0] hw_clr_in,   // Hardware clear per bit
  output logic      [WIDTH-1:0] value_out    // Stored field value
);

  initial
  begin
    if (WIDTH < 1 || WIDTH > 32 || MODE < FA_RW || MODE > FA_W1S)
      $error("field_cell: unsupported WIDTH or MODE");
  end

  logic [WIDTH-1:0] value_ff;
  logic [WIDTH-1:0] nxt_value;
  logic [WIDTH-1:0] sw_clr;
  logic [WIDTH-1:0] sw_set;

  always_comb
  begin
    sw_clr = '0;
    sw_set = '0;
    case (MODE)
      FA_RC:  sw_clr = rd_in ? '1 : '0;
      FA_WC:  sw_clr = wr_in ? '1 : '0;
      FA_W1C: sw_clr = wr_in ? wdata_in : '0;
      FA_W1S: sw_set = wr_in ? wdata_in : '0;
      default:
      begin
        sw_clr = '0;
        sw_set = '0;
      end
    endcase
    if (MODE == FA_RW)
      nxt_value = wr_in ? wdata_in : value_ff;
    else
      nxt_value = ((value_ff & ~sw_clr & ~hw_clr_in) | sw_set) | hw_set_in;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      value_ff <= RST_VAL;
    else
      value_ff <= nxt_value;
  end

  assign value_out = value_ff;

endmodule // field_cell

// ==== reg_field_bank.sv ====
`timescale 1ns/1ps

// How it works
// - Read-clear field clears after being read
// - Any write clears write-any-clears register
// - Writing one clears only that bit
// - Write-back clears reported bits, spares new
// - Write-only clear register reads as zero
// - Writing one sets, zero is ignored
// - Address is base plus register offset
// - Write-only register accepts writes, reads zero
// - Fields take documented values after reset
module reg_field_bank
  import reg_access_pkg::*;
#(
  parameter int          FLAG_W    = 8,
  parameter logic [31:0] BASE_ADDR = DEF_BASE
)
(
  input  wire logic              core_clk_in,    // System clock, 200 MHz
  input  wire logic              rstn_in,        // Async reset, active low
  input  wire logic [31:0]       addr_in,        // Byte address of access
  input  wire logic              wr_in,          // Write request, one cycle
  input  wire logic              rd_in,          // Read request, one cycle
  input  wire logic [31:0]       wdata_in,       // Write data
  output logic      [31:0]       rdata_out,      // Read data
  output logic                   ack_out,        // Access done pulse
  output logic                   err_out,        // Unmapped address pulse
  input  wire logic [FLAG_W-1:0] event_in,       // Event pins, rising edge
  input  wire logic [FLAG_W-1:0] error_in,       // Error pins, level
  input  wire logic [FLAG_W-1:0] fault_in,       // Fault pins, level
  input  wire logic [FLAG_W-1:0] done_in,        // Clears set requests
  input  wire logic [FLAG_W-1:0] pend_in,        // Pending pins, level
  output logic      [FLAG_W-1:0] ctrl_out,       // Control register value
  output logic      [FLAG_W-1:0] int_status_out, // Event status bits
  output logic      [FLAG_W-1:0] set_req_out,    // Set request bits
  output logic      [FLAG_W-1:0] pending_out,    // Pending bits
  output logic      [31:0]       cmd_out,        // Last command word
  output logic                   cmd_strobe_out  // Command written pulse
);

  initial
  begin
    if (FLAG_W < 1 || FLAG_W > 32)
      $error("reg_field_bank: FLAG_W must be 1 to 32");
    if (BASE_ADDR[OFS_BITS-1:0] != '0)
      $error("reg_field_bank: BASE_ADDR must be aligned to the bank window");
  end

  localparam int SYNC_W = 5 * FLAG_W;

  function automatic logic [NUM_REGS-1:0] reg_sel(input logic [31:0] addr);
    logic [31:0]          ofs;
    logic [NUM_REGS-1:0]  sel;
    ofs = addr - BASE_ADDR;
    sel = '0;
    if (ofs[31:OFS_BITS] == '0 && ofs[1:0] == 2'b00)
    begin
      case (ofs[OFS_BITS-1:0])
        OFS_CTRL:   sel[SEL_CTRL]   = 1'b1;
        OFS_STATUS: sel[SEL_STATUS] = 1'b1;
        OFS_ERRLAT: sel[SEL_ERRLAT] = 1'b1;
        OFS_FAULT:  sel[SEL_FAULT]  = 1'b1;
        OFS_INTST:  sel[SEL_INTST]  = 1'b1;
        OFS_SETREQ: sel[SEL_SETREQ] = 1'b1;
        OFS_PEND:   sel[SEL_PEND]   = 1'b1;
        OFS_CMD:    sel[SEL_CMD]    = 1'b1;
        default:    sel = '0;
      endcase
    end
    return sel;
  endfunction

  // Pin synchronisers; meta_ff feeds only sync_ff
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  logic [FLAG_W-1:0] event_prev_ff;

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= {pend_in, done_in, fault_in, error_in, event_in};
      sync_ff <= meta_ff;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      event_prev_ff <= '0;
    else
      event_prev_ff <= sync_ff[FLAG_W-1:0];
  end

  logic [FLAG_W-1:0] event_s;
  logic [FLAG_W-1:0] error_s;
  logic [FLAG_W-1:0] fault_s;
  logic [FLAG_W-1:0] done_s;
  logic [FLAG_W-1:0] pend_s;
  logic [FLAG_W-1:0] event_rise;

  assign event_s    = sync_ff[0*FLAG_W +: FLAG_W];
  assign error_s    = sync_ff[1*FLAG_W +: FLAG_W];
  assign fault_s    = sync_ff[2*FLAG_W +: FLAG_W];
  assign done_s     = sync_ff[3*FLAG_W +: FLAG_W];
  assign pend_s     = sync_ff[4*FLAG_W +: FLAG_W];
  assign event_rise = event_s & ~event_prev_ff;

  // Access qualification; a write beats a read issued in the same cycle
  logic [NUM_REGS-1:0] sel;
  logic                wr_go;
  logic                rd_go;
  logic [NUM_REGS-1:0] wr_sel;
  logic [NUM_REGS-1:0] rd_sel;

  assign sel    = reg_sel(addr_in);
  assign wr_go  = wr_in;
  assign rd_go  = rd_in & ~wr_in;
  assign wr_sel = wr_go ? sel : '0;
  assign rd_sel = rd_go ? sel : '0;

  logic [FLAG_W-1:0] ctrl_val;
  logic [FLAG_W-1:0] errlat_val;
  logic [FLAG_W-1:0] fault_val;
  logic [FLAG_W-1:0] intst_val;
  logic [FLAG_W-1:0] setreq_val;
  logic [FLAG_W-1:0] pend_val;
  logic [FLAG_W-1:0] wdata_f;

  assign wdata_f = wdata_in[FLAG_W-1:0];

  field_cell #(.WIDTH(FLAG_W), .MODE(FA_RW), .RST_VAL(CTRL_RST[FLAG_W-1:0])) u_ctrl
  (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .wr_in       (wr_sel[SEL_CTRL]),
    .rd_in       (rd_sel[SEL_CTRL]),
    .wdata_in    (wdata_f),
    .hw_set_in   ('0),
    .hw_clr_in   ('0),
    .value_out   (ctrl_val)
  );

  field_cell #(.WIDTH(FLAG_W), .MODE(FA_RC), .RST_VAL(ZERO_RST[FLAG_W-1:0])) u_errlat
  (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .wr_in       (wr_sel[SEL_ERRLAT]),
    .rd_in       (rd_sel[SEL_ERRLAT]),
    .wdata_in    (wdata_f),
    .hw_set_in   (error_s),
    .hw_clr_in   ('0),
    .value_out   (errlat_val)
  );

  field_cell #(.WIDTH(FLAG_W), .MODE(FA_WC), .RST_VAL(ZERO_RST[FLAG_W-1:0])) u_fault
  (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .wr_in       (wr_sel[SEL_FAULT]),
    .rd_in       (rd_sel[SEL_FAULT]),
    .wdata_in    (wdata_f),
    .hw_set_in   (fault_s),
    .hw_clr_in   ('0),
    .value_out   (fault_val)
  );

  field_cell #(.WIDTH(FLAG_W), .MODE(FA_W1C), .RST_VAL(ZERO_RST[FLAG_W-1:0])) u_intst
  (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .wr_in       (wr_sel[SEL_INTST]),
    .rd_in       (rd_sel[SEL_INTST]),
    .wdata_in    (wdata_f),
    .hw_set_in   (event_rise & ctrl_val),
    .hw_clr_in   ('0),
    .value_out   (intst_val)
  );

  // set requests, retired by done pins
  field_cell #(.WIDTH(FLAG_W), .MODE(FA_W1S), .RST_VAL(ZERO_RST[FLAG_W-1:0])) u_setreq
  (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .wr_in       (wr_sel[SEL_SETREQ]),
    .rd_in       (rd_sel[SEL_SETREQ]),
    .wdata_in    (wdata_f),
    .hw_set_in   ('0),
    .hw_clr_in   (done_s),
    .value_out   (setreq_val)
  );

  field_cell #(.WIDTH(FLAG_W), .MODE(FA_W1C), .RST_VAL(ZERO_RST[FLAG_W-1:0])) u_pend
  (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .wr_in       (wr_sel[SEL_PEND]),
    .rd_in       (rd_sel[SEL_PEND]),
    .wdata_in    (wdata_f),
    .hw_set_in   (pend_s),
    .hw_clr_in   ('0),
    .value_out   (pend_val)
  );

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cmd_out        <= ZERO_RST;
      cmd_strobe_out <= 1'b0;
    end
    else
    begin
      cmd_strobe_out <= wr_sel[SEL_CMD];
      if (wr_sel[SEL_CMD])
        cmd_out <= wdata_in;
    end
  end

  // Reserved bits above FLAG_W always read zero
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = '0;
    unique case (1'b1)
      sel[SEL_CTRL]:   rd_mux = 32'(ctrl_val);
      sel[SEL_STATUS]: rd_mux = 32'(event_s);
      sel[SEL_ERRLAT]: rd_mux = 32'(errlat_val);
      sel[SEL_FAULT]:  rd_mux = 32'(fault_val);
      sel[SEL_INTST]:  rd_mux = 32'(intst_val);
      sel[SEL_SETREQ]: rd_mux = 32'(setreq_val);
      sel[SEL_PEND]:   rd_mux = '0;
      sel[SEL_CMD]:    rd_mux = '0;
      default:         rd_mux = '0;
    endcase
  end

  // Read data is captured before the read-clear lands, so the reader sees the old value
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_out <= '0;
      ack_out   <= 1'b0;
      err_out   <= 1'b0;
    end
    else
    begin
      ack_out   <= wr_go | rd_go;
      err_out   <= (wr_go | rd_go) & (sel == '0);
      rdata_out <= rd_go ? rd_mux : '0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl_out       <= CTRL_RST[FLAG_W-1:0];
      int_status_out <= '0;
      set_req_out    <= '0;
      pending_out    <= '0;
    end
    else
    begin
      ctrl_out       <= ctrl_val;
      int_status_out <= intst_val;
      set_req_out    <= setreq_val;
      pending_out    <= pend_val;
    end
  end

endmodule // reg_field_bank

// ==== reg_field_bank_properties.sv ====
`timescale 1ns/1ps

module reg_field_bank_chk
  import reg_access_pkg::*;
#(
  parameter int          FLAG_W    = 8,
  parameter logic [31:0] BASE_ADDR = DEF_BASE
)
(
  input wire logic              core_clk_in,    // Clock
  input wire logic              rstn_in,        // Reset, active low
  input wire logic [31:0]       addr_in,        // Address
  input wire logic              wr_in,          // Write
  input wire logic              rd_in,          // Read
  input wire logic [31:0]       wdata_in,       // Write data
  input wire logic [31:0]       rdata_out,      // Read data
  input wire logic              ack_out,        // Done pulse
  input wire logic              err_out,        // Error pulse
  input wire logic [FLAG_W-1:0] ctrl_out,       // Control copy
  input wire logic [FLAG_W-1:0] set_req_out,    // Set requests
  input wire logic [31:0]       cmd_out,        // Command word
  input wire logic              cmd_strobe_out  // Command pulse
);
  localparam logic [31:0] A_CTRL = BASE_ADDR + {20'h0_0000, OFS_CTRL};
  localparam logic [31:0] A_SET  = BASE_ADDR + {20'h0_0000, OFS_SETREQ};
  localparam logic [31:0] A_PEND = BASE_ADDR + {20'h0_0000, OFS_PEND};
  localparam logic [31:0] A_CMD  = BASE_ADDR + {20'h0_0000, OFS_CMD};
  logic req;
  logic rd_only;
  assign req     = wr_in | rd_in;
  assign rd_only = rd_in & ~wr_in;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  chk_ack_follows: assert property (req |=> ack_out)
    else $error("access not acknowledged");
  chk_ack_only_req: assert property (!req |=> !ack_out && !err_out)
    else $error("acknowledge without access");
  chk_misalign_err: assert property ((req && addr_in[1:0] != 2'b00) |=> err_out)
    else $error("misaligned access not refused");
  chk_err_with_ack: assert property (err_out |-> ack_out)
    else $error("error without acknowledge");
  chk_wo_reads_zero: assert property (
    (rd_only && (addr_in == A_PEND || addr_in == A_CMD)) |=> rdata_out == 32'h0000_0000)
    else $error("write-only register read nonzero");
  chk_cmd_capture: assert property (
    (wr_in && addr_in == A_CMD) |=> cmd_strobe_out && cmd_out == $past(wdata_in))
    else $error("command word not taken");
  chk_rw_store: assert property (
    (wr_in && addr_in == A_CTRL) |=> ##1 ctrl_out == $past(wdata_in[FLAG_W-1:0], 2))
    else $error("control value not stored");
  chk_w1s_sets: assert property ((wr_in && addr_in == A_SET) |=> ##1
    (set_req_out & $past(wdata_in[FLAG_W-1:0], 2)) == $past(wdata_in[FLAG_W-1:0], 2))
    else $error("written ones not set");
  chk_reset_vals: assert property ($rose(rstn_in) |-> ctrl_out == CTRL_RST[FLAG_W-1:0]
    && set_req_out == '0 && cmd_out == ZERO_RST && !ack_out)
    else $error("wrong value after reset");

  cover property (rd_only ##1 (ack_out && rdata_out != 32'h0000_0000));
  cover property (err_out);
  cover property (cmd_strobe_out);
endmodule // reg_field_bank_chk

bind reg_field_bank reg_field_bank_chk #(.FLAG_W(FLAG_W), .BASE_ADDR(BASE_ADDR)) i_chk (
  .core_clk_in, .rstn_in, .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out, .ack_out,
  .err_out, .ctrl_out, .set_req_out, .cmd_out, .cmd_strobe_out);

// ==== register_field_access_types_bench.sv ====
`timescale 1ns/1ps

module register_field_access_types_bench
  import reg_access_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [7:0]  ev = '0, er = '0, fl = '0, dn = '0, pd = '0;
  logic [31:0] rdata, cmd, v;
  logic        ack, err, cstb, ve;
  logic [7:0]  ctrl, ist, sreq, pnd;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cycles = 0;

  always #2.5 clk = ~clk;

  reg_field_bank i_dut (.core_clk_in(clk), .rstn_in(rstn), .addr_in(addr), .wr_in(wr),
    .rd_in(rd), .wdata_in(wdata), .rdata_out(rdata), .ack_out(ack), .err_out(err),
    .event_in(ev), .error_in(er), .fault_in(fl), .done_in(dn), .pend_in(pd),
    .ctrl_out(ctrl), .int_status_out(ist), .set_req_out(sreq), .pending_out(pnd),
    .cmd_out(cmd), .cmd_strobe_out(cstb));

  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] at(input logic [11:0] o);
    return DEF_BASE + {20'h0_0000, o};
  endfunction

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One access; the registered answer is sampled at the next falling edge, one cycle after issue
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    v = rdata;
    ve = err;
    check("ack", {31'h0, ack}, 32'h0000_0001);
  endtask

  task automatic t_reset;
    check("ctrl_out", {24'h0, ctrl}, CTRL_RST);
    for (int i = 0; i < NUM_REGS; i++)
    begin
      acc(1'b0, at(12'(4 * i)), '0);
      check("reset read", v, (i == SEL_CTRL) ? CTRL_RST : ZERO_RST);
    end
    $display("reset values done");
  endtask

  task automatic t_rw;
    acc(1'b1, at(OFS_CTRL), 32'hFFFF_FF5A);
    acc(1'b0, at(OFS_CTRL), '0);
    check("ctrl read", v, 32'h0000_005A);
    check("ctrl_out", {24'h0, ctrl}, 32'h0000_005A);
    // Read-modify-write keeps every bit read back, reserved ones included
    acc(1'b1, at(OFS_CTRL), v | 32'h0000_00A5);
    acc(1'b0, at(OFS_CTRL), '0);
    check("ctrl rmw", v, 32'h0000_00FF);
    $display("read-write done");
  endtask

  task automatic t_rc_wc;
    er = 8'h24;
    fl = 8'h81;
    idle(4);
    er = '0;
    fl = '0;
    idle(4);
    acc(1'b0, at(OFS_ERRLAT), '0);
    check("errlat", v, 32'h0000_0024);
    acc(1'b0, at(OFS_ERRLAT), '0);
    check("errlat again", v, 32'h0000_0000);
    acc(1'b0, at(OFS_FAULT), '0);
    check("fault", v, 32'h0000_0081);
    acc(1'b1, at(OFS_FAULT), '0);
    acc(1'b0, at(OFS_FAULT), '0);
    check("fault cleared", v, 32'h0000_0000);
    $display("read-clear and write-clear done");
  endtask

  task automatic t_w1c;
    logic [31:0] seen;
    ev = 8'h0F;
    idle(6);
    acc(1'b0, at(OFS_INTST), '0);
    seen = v;
    check("intst", seen, 32'h0000_000F);
    ev = 8'h1F;
    idle(6);
    acc(1'b1, at(OFS_INTST), seen);
    acc(1'b0, at(OFS_INTST), '0);
    check("intst spared", v, 32'h0000_0010);
    acc(1'b1, at(OFS_INTST), '0);
    acc(1'b0, at(OFS_INTST), '0);
    check("intst zero write", v, 32'h0000_0010);
    check("int_status_out", {24'h0, ist}, 32'h0000_0010);
    acc(1'b1, at(OFS_INTST), 32'h0000_0010);
    // The output copy trails the register by one cycle
    idle(1);
    check("int_status_out", {24'h0, ist}, 32'h0000_0000);
    acc(1'b0, at(OFS_INTST), '0);
    check("intst cleared", v, 32'h0000_0000);
    $display("write-one-clear done");
  endtask

  task automatic t_w1s;
    acc(1'b1, at(OFS_SETREQ), 32'h0000_0003);
    acc(1'b1, at(OFS_SETREQ), 32'h0000_0000);
    acc(1'b1, at(OFS_SETREQ), 32'h0000_0010);
    acc(1'b0, at(OFS_SETREQ), '0);
    check("setreq", v, 32'h0000_0013);
    check("set_req_out", {24'h0, sreq}, 32'h0000_0013);
    dn = 8'h13;
    idle(4);
    dn = '0;
    acc(1'b0, at(OFS_SETREQ), '0);
    check("setreq done", v, 32'h0000_0000);
    check("set_req_out done", {24'h0, sreq}, 32'h0000_0000);
    $display("write-one-set done");
  endtask

  task automatic t_wo;
    pd = 8'h3C;
    idle(4);
    pd = '0;
    acc(1'b0, at(OFS_PEND), '0);
    check("pend read", v, 32'h0000_0000);
    check("pending_out", {24'h0, pnd}, 32'h0000_003C);
    acc(1'b1, at(OFS_PEND), 32'h0000_000C);
    idle(1);
    check("pending_out", {24'h0, pnd}, 32'h0000_0030);
    acc(1'b1, at(OFS_CMD), 32'h1234_5678);
    check("cmd_strobe_out", {31'h0, cstb}, 32'h0000_0001);
    check("cmd_out", cmd, 32'h1234_5678);
    acc(1'b0, at(OFS_CMD), '0);
    check("cmd read", v, 32'h0000_0000);
    $display("write-only done");
  endtask

  task automatic t_bad;
    acc(1'b0, DEF_BASE + 32'h0000_0002, '0);
    check("misaligned err", {31'h0, ve}, 32'h0000_0001);
    acc(1'b1, DEF_BASE + 32'h0000_1000, '0);
    check("outside err", {31'h0, ve}, 32'h0000_0001);
    // Software writes the reset value into the read-only register
    acc(1'b1, at(OFS_STATUS), '0);
    acc(1'b0, at(OFS_STATUS), '0);
    check("status", v, 32'h0000_001F);
    check("status err", {31'h0, ve}, 32'h0000_0000);
    $display("address decode done");
  endtask

  // Mid-run reset must bring written registers back to their reset values
  task automatic t_reset_again;
    acc(1'b1, at(OFS_CTRL), 32'h0000_0033);
    acc(1'b1, at(OFS_SETREQ), 32'h0000_0004);
    acc(1'b1, at(OFS_CMD), 32'h0000_0055);
    rstn = 1'b0;
    idle(2);
    rstn = 1'b1;
    idle(1);
    check("ctrl_out", {24'h0, ctrl}, CTRL_RST);
    check("set_req_out", {24'h0, sreq}, ZERO_RST);
    check("cmd_out", cmd, ZERO_RST);
    acc(1'b0, at(OFS_CTRL), '0);
    check("ctrl after reset", v, CTRL_RST);
    $display("second reset done");
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    idle(4);
    rstn = 1'b1;
    idle(1);
    t_reset();
    t_rw();
    t_rc_wc();
    t_w1c();
    t_w1s();
    t_wo();
    t_bad();
    t_reset_again();
    report_and_stop();
  end
endmodule // register_field_access_types_bench
